// [rtl/jsg_pkg.sv]
// constants, states and carriers of the jtag scan security gate
package jsg_pkg;
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
  localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;
  localparam logic [IR_W-1:0] OP_IDCODE = 8'h0f;
  localparam logic [IR_W-1:0] OP_USERCODE = 8'h0e;
  localparam logic [IR_W-1:0] OP_HIGHZ = 8'h07;
  localparam logic [IR_W-1:0] OP_CLAMP = 8'h05;
  localparam logic [IR_W-1:0] OP_PROG = 8'h30;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam int ID_W = 32;
  // one cell per pin path, in this order from tdo side
  localparam int CELL_W = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int CMD_W = 3;
  localparam int DATA_W = 8;
  localparam logic [CMD_W-1:0] CMD_ARR_WR = 3'h0;
  localparam logic [CMD_W-1:0] CMD_ARR_VFY = 3'h1;
  localparam logic [CMD_W-1:0] CMD_MEM_RD = 3'h2;
  localparam logic [CMD_W-1:0] CMD_MEM_WR = 3'h3;
  localparam logic [CMD_W-1:0] CMD_SEC_SET = 3'h4;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jsg_tap_t;
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [DATA_W-1:0] data;
  } jsg_req_t;
  // bit 0 write protect, bit 1 permanent settings, bit 2 permanent lock
  typedef struct packed {
    logic perm_lock;
    logic perm_sec;
    logic wprot;
  } jsg_lock_t;
  typedef struct packed {
    logic extest;
    logic highz;
    logic clamp;
  } jsg_mode_t;
  localparam int REQ_W = $bits(jsg_req_t);
  localparam int LOCK_W = $bits(jsg_lock_t);
  // tap walk, one step per rising tck
  function automatic jsg_tap_t jsg_tap_next(input jsg_tap_t s, input logic tms);
    jsg_tap_t n;
    unique case (s)
      S_TLR: n = tms ? S_TLR : S_RTI;
      S_RTI: n = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: n = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: n = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: n = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: n = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: n = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: n = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: n = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: n = tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: n = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: n = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: n = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: n = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: n = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: n = tms ? S_SEL_DR : S_RTI;
    endcase
    return n;
  endfunction : jsg_tap_next
endpackage : jsg_pkg

// [rtl/jsg_gate.sv]
// tap, boundary chain, request crossing, lock gate and request fifo
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for levels
module jsg_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  // first flop feeds the second and nothing else
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule : jsg_sync

////////////////////////////////////////////////////////////////////////////////
// flip-flop fifo with valid and ready on both sides
module jsg_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end
  assign in_ready_out = cnt_reg != (AW+1)'(D);
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out = mem_reg[rp_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // data storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_in;
    end
  end
  // pointers wrap by power-of-two depth
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule : jsg_fifo

////////////////////////////////////////////////////////////////////////////////
// test access port with boundary chain and programming gate
module jsg_gate #(
  parameter int N_PINS = 4,
  parameter logic [31:0] ID_CODE = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] USER_CODE = 32'h0000_0000,
  parameter int FIFO_D = jsg_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic tck_in,
  input wire logic trstn_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic freeze_in,
  input wire logic [N_PINS-1:0] pad_in,
  input wire logic [N_PINS-1:0] core_out_in,
  input wire logic [N_PINS-1:0] core_oe_in,
  output logic [N_PINS-1:0] pad_out_out,
  output logic [N_PINS-1:0] pad_oe_out,
  output logic [N_PINS-1:0] core_in_out,
  output logic req_valid_out,
  output jsg_pkg::jsg_req_t req_out,
  input wire logic req_ready_in,
  output logic rej_out,
  output jsg_pkg::jsg_lock_t lock_out
);
  localparam int BSR_W = N_PINS * jsg_pkg::CELL_W;
  localparam int RW = jsg_pkg::REQ_W;
  if (N_PINS < 1) begin : g_bad_pins
    $error("at least one pin is needed");
  end
  jsg_pkg::jsg_tap_t st_reg;
  logic frz_s;
  logic [3*N_PINS-1:0] pin_s;
  logic [BSR_W-1:0] cap_vec;
  logic [jsg_pkg::IR_W-1:0] ir_sh_reg;
  logic [jsg_pkg::IR_W-1:0] ir_reg;
  logic [BSR_W-1:0] bsr_sh_reg;
  logic [BSR_W-1:0] bsr_upd_reg;
  logic [jsg_pkg::ID_W-1:0] id_sh_reg;
  logic byp_reg;
  jsg_pkg::jsg_req_t prog_sh_reg;
  jsg_pkg::jsg_req_t req_word_reg;
  logic req_tgl_reg;
  logic upd_tgl_reg;
  logic ack_s;
  logic ack_reg;
  logic [jsg_pkg::IR_W-1:0] ir_nx;
  logic busy;
  jsg_pkg::jsg_mode_t mode_reg;
  jsg_pkg::jsg_mode_t mode_next;
  logic sel_bsr;
  logic sel_id;
  logic sel_prog;
  logic tdo_bit;
  logic tdo_reg;
  logic tdo_oe_reg;

  //////////////////////////////////////////////////////////////////////////////
  // test clock side
  jsg_sync #(.W(1)) u_frz_sync (
    .clk_in(tck_in), .rstn_in(trstn_in), .d_in(freeze_in), .q_out(frz_s));
  jsg_sync #(.W(3*N_PINS)) u_pin_sync (
    .clk_in(tck_in), .rstn_in(trstn_in), .d_in({core_oe_in, core_out_in, pad_in}),
    .q_out(pin_s));
  jsg_sync #(.W(1)) u_ack_sync (
    .clk_in(tck_in), .rstn_in(trstn_in), .d_in(ack_reg), .q_out(ack_s));

  // pin, core output and enable paths into each cell
  for (genvar i = 0; i < N_PINS; i++) begin : g_cell
    assign cap_vec[i*jsg_pkg::CELL_W+jsg_pkg::CELL_IN] = pin_s[i];
    assign cap_vec[i*jsg_pkg::CELL_W+jsg_pkg::CELL_OUT] = pin_s[N_PINS+i];
    assign cap_vec[i*jsg_pkg::CELL_W+jsg_pkg::CELL_OE] = pin_s[2*N_PINS+i];
  end

  // opcode decode; unknown opcodes fall to bypass
  assign sel_bsr = ir_reg == jsg_pkg::OP_EXTEST || ir_reg == jsg_pkg::OP_SAMPLE;
  assign sel_id = ir_reg == jsg_pkg::OP_IDCODE || ir_reg == jsg_pkg::OP_USERCODE;
  assign sel_prog = ir_reg == jsg_pkg::OP_PROG;
  // mode follows the incoming opcode, so it lands at update-ir even if tck then stops
  assign ir_nx = (st_reg == jsg_pkg::S_TLR) ? jsg_pkg::OP_IDCODE :
    (st_reg == jsg_pkg::S_UPD_IR) ? ir_sh_reg : ir_reg;
  assign mode_next.extest = ir_nx == jsg_pkg::OP_EXTEST;
  assign mode_next.highz = ir_nx == jsg_pkg::OP_HIGHZ;
  assign mode_next.clamp = ir_nx == jsg_pkg::OP_CLAMP;
  assign busy = req_tgl_reg != ack_s;

  // controller walk; a frozen device may not take the tap out of reset
  always_ff @(posedge tck_in or negedge trstn_in) begin
    if (!trstn_in) st_reg <= jsg_pkg::S_TLR;
    else if (frz_s) st_reg <= jsg_pkg::S_TLR;
    else st_reg <= jsg_pkg::jsg_tap_next(st_reg, tms_in);
  end

  // instruction path, lsb leaves first
  always_ff @(posedge tck_in or negedge trstn_in) begin
    if (!trstn_in) begin
      ir_sh_reg <= jsg_pkg::IR_CAPTURE;
      ir_reg <= jsg_pkg::OP_IDCODE;
    end else begin
      if (st_reg == jsg_pkg::S_TLR) ir_reg <= jsg_pkg::OP_IDCODE;
      else if (st_reg == jsg_pkg::S_UPD_IR) ir_reg <= ir_sh_reg;
      if (st_reg == jsg_pkg::S_CAP_IR) ir_sh_reg <= jsg_pkg::IR_CAPTURE;
      else if (st_reg == jsg_pkg::S_SH_IR) ir_sh_reg <= {tdi_in, ir_sh_reg[7:1]};
    end
  end

  // data registers; all shift, only the selected one reaches tdo
  always_ff @(posedge tck_in or negedge trstn_in) begin
    if (!trstn_in) begin
      bsr_sh_reg <= '0;
      id_sh_reg <= '0;
      byp_reg <= 1'b0;
      prog_sh_reg <= '0;
    end else if (st_reg == jsg_pkg::S_CAP_DR) begin
      bsr_sh_reg <= cap_vec;
      id_sh_reg <= (ir_reg == jsg_pkg::OP_USERCODE) ? USER_CODE : ID_CODE;
      byp_reg <= 1'b0;
      prog_sh_reg <= jsg_pkg::jsg_req_t'(RW'(busy));
    end else if (st_reg == jsg_pkg::S_SH_DR) begin
      bsr_sh_reg <= {tdi_in, bsr_sh_reg[BSR_W-1:1]};
      id_sh_reg <= {tdi_in, id_sh_reg[jsg_pkg::ID_W-1:1]};
      byp_reg <= tdi_in;
      prog_sh_reg <= {tdi_in, prog_sh_reg[RW-1:1]};
    end
  end

  // update stage; held stable until the next toggle so the core copy is clean
  always_ff @(posedge tck_in or negedge trstn_in) begin
    if (!trstn_in) begin
      bsr_upd_reg <= '0;
      mode_reg <= '0;
      upd_tgl_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (st_reg == jsg_pkg::S_UPD_DR && sel_bsr) bsr_upd_reg <= bsr_sh_reg;
      if ((st_reg == jsg_pkg::S_UPD_DR && sel_bsr) || mode_next != mode_reg) begin
        upd_tgl_reg <= ~upd_tgl_reg;
      end
    end
  end

  // program request: a word is refused while the previous is unanswered
  always_ff @(posedge tck_in or negedge trstn_in) begin
    if (!trstn_in) begin
      req_word_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (st_reg == jsg_pkg::S_UPD_DR && sel_prog && !busy) begin
      req_word_reg <= prog_sh_reg;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // serial output source
  always_comb begin
    if (st_reg == jsg_pkg::S_SH_IR) tdo_bit = ir_sh_reg[0];
    else if (sel_bsr) tdo_bit = bsr_sh_reg[0];
    else if (sel_id) tdo_bit = id_sh_reg[0];
    else if (sel_prog) tdo_bit = prog_sh_reg[0];
    else tdo_bit = byp_reg;
  end

  // tdo changes on the falling edge, driven only while shifting
  always_ff @(negedge tck_in or negedge trstn_in) begin
    if (!trstn_in) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_bit;
      tdo_oe_reg <= st_reg == jsg_pkg::S_SH_DR || st_reg == jsg_pkg::S_SH_IR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core clock side
  logic upd_s;
  logic rq_s;
  logic upd_seen_reg;
  jsg_pkg::jsg_mode_t mode_c_reg;
  logic [BSR_W-1:0] bsr_c_reg;
  logic [N_PINS-1:0] pad_out_reg;
  logic [N_PINS-1:0] pad_oe_reg;
  logic [N_PINS-1:0] bs_out;
  logic [N_PINS-1:0] bs_oe;
  jsg_pkg::jsg_lock_t lock_reg;
  jsg_pkg::jsg_req_t w;
  logic pend;
  logic is_sec;
  logic blocked;
  logic f_push;
  logic f_ready;
  logic f_valid;
  jsg_pkg::jsg_req_t f_data;
  logic ov_reg;
  jsg_pkg::jsg_req_t oreq_reg;
  logic rej_reg;

  jsg_sync #(.W(2)) u_tgl_sync (
    .clk_in(core_clk_in), .rstn_in(rstn_in), .d_in({upd_tgl_reg, req_tgl_reg}),
    .q_out({upd_s, rq_s}));
  jsg_sync #(.W(N_PINS)) u_core_in_sync (
    .clk_in(core_clk_in), .rstn_in(rstn_in), .d_in(pad_in), .q_out(core_in_out));

  for (genvar i = 0; i < N_PINS; i++) begin : g_drive
    assign bs_out[i] = bsr_c_reg[i*jsg_pkg::CELL_W+jsg_pkg::CELL_OUT];
    assign bs_oe[i] = bsr_c_reg[i*jsg_pkg::CELL_W+jsg_pkg::CELL_OE];
  end

  // copy mode and cell values once the toggle has settled
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      upd_seen_reg <= 1'b0;
      mode_c_reg <= '0;
      bsr_c_reg <= '0;
    end else begin
      upd_seen_reg <= upd_s;
      if (upd_s != upd_seen_reg) begin
        mode_c_reg <= mode_reg;
        bsr_c_reg <= bsr_upd_reg;
      end
    end
  end

  // pin drive: float, cells, or the core's own logic
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pad_out_reg <= '0;
      pad_oe_reg <= '0;
    end else if (mode_c_reg.highz) begin
      pad_out_reg <= core_out_in;
      pad_oe_reg <= '0;
    end else if (mode_c_reg.extest || mode_c_reg.clamp) begin
      pad_out_reg <= bs_out;
      pad_oe_reg <= bs_oe;
    end else begin
      pad_out_reg <= core_out_in;
      pad_oe_reg <= core_oe_in;
    end
  end

  // lock gate on each arriving program word
  assign w = req_word_reg;
  assign pend = rq_s != ack_reg;
  assign is_sec = w.cmd == jsg_pkg::CMD_SEC_SET;
  always_comb begin
    unique case (w.cmd)
      jsg_pkg::CMD_ARR_WR: blocked = lock_reg.perm_lock || lock_reg.wprot;
      jsg_pkg::CMD_ARR_VFY: blocked = lock_reg.perm_lock;
      jsg_pkg::CMD_MEM_RD: blocked = lock_reg.perm_lock;
      jsg_pkg::CMD_MEM_WR: blocked = lock_reg.perm_lock;
      jsg_pkg::CMD_SEC_SET: blocked = lock_reg.perm_sec || lock_reg.perm_lock;
      default: blocked = 1'b1;
    endcase
  end
  assign f_push = pend && !blocked && !is_sec;

  // answer the word once it is taken, refused or applied; full fifo stalls it
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
      rej_reg <= 1'b0;
      lock_reg <= '0;
    end else begin
      if (pend && (blocked || is_sec || f_ready)) ack_reg <= ~ack_reg;
      rej_reg <= pend && blocked;
      if (pend && is_sec && !blocked) begin
        lock_reg <= jsg_pkg::jsg_lock_t'(w.data[jsg_pkg::LOCK_W-1:0]);
      end
    end
  end

  jsg_fifo #(.W(RW), .D(FIFO_D)) u_fifo (
    .clk_in(core_clk_in), .rstn_in(rstn_in), .in_valid_in(f_push),
    .in_data_in(w), .in_ready_out(f_ready), .out_valid_out(f_valid),
    .out_data_out(f_data), .out_ready_in(!ov_reg || req_ready_in));

  // registered output slice so the port comes from a flop
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ov_reg <= 1'b0;
      oreq_reg <= '0;
    end else if (!ov_reg || req_ready_in) begin
      ov_reg <= f_valid;
      oreq_reg <= f_data;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;
  assign pad_out_out = pad_out_reg;
  assign pad_oe_out = pad_oe_reg;
  assign req_valid_out = ov_reg;
  assign req_out = oreq_reg;
  assign rej_out = rej_reg;
  assign lock_out = lock_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_tms_high5;
    tms_in [*5];
  endsequence
  sequence s_upd_ir(logic [7:0] op);
    st_reg == jsg_pkg::S_UPD_IR && ir_sh_reg == op;
  endsequence

  a_tap_reset5: assert property (@(posedge tck_in) disable iff (!trstn_in)
    s_tms_high5 |=> st_reg == jsg_pkg::S_TLR) else $error("tap missed reset");
  a_frz_hold: assert property (@(posedge tck_in) disable iff (!trstn_in)
    frz_s |=> st_reg == jsg_pkg::S_TLR) else $error("tap left reset while frozen");
  a_ir_reset: assert property (@(posedge tck_in) disable iff (!trstn_in)
    st_reg == jsg_pkg::S_TLR |=> ir_reg == jsg_pkg::OP_IDCODE) else $error("ir not idcode");
  a_chain_shift: assert property (@(posedge tck_in) disable iff (!trstn_in)
    st_reg == jsg_pkg::S_SH_DR |=> bsr_sh_reg[BSR_W-1] == $past(tdi_in)
    && bsr_sh_reg[0] == $past(bsr_sh_reg[1])) else $error("chain not shifting");
  a_ext_decode: assert property (@(posedge tck_in) disable iff (!trstn_in)
    s_upd_ir(jsg_pkg::OP_EXTEST) |=> mode_reg.extest) else $error("extest missed");
  a_hz_decode: assert property (@(posedge tck_in) disable iff (!trstn_in)
    s_upd_ir(jsg_pkg::OP_HIGHZ) |=> mode_reg.highz) else $error("highz missed");
  a_tdo_drive: assert property (@(negedge tck_in) disable iff (!trstn_in)
    st_reg == jsg_pkg::S_SH_DR |=> tdo_oe_out) else $error("tdo not driven");
  a_wp_block: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pend && lock_reg.wprot && w.cmd == jsg_pkg::CMD_ARR_WR |-> !f_push ##1 rej_out)
    else $error("write passed protect");
  a_sec_fixed: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    lock_reg.perm_sec |=> lock_reg == $past(lock_reg)) else $error("settings changed");
  a_perm_lock: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    lock_reg.perm_lock |-> !f_push) else $error("access passed permanent lock");
  a_pad_highz: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    mode_c_reg.highz |=> pad_oe_out == '0) else $error("pin driven in highz");
endmodule : jsg_gate

// [tb/jsg_jtag_host.sv]
// test controller model driving the test port; tck runs only inside frames
`timescale 1ns/1ps

module jsg_jtag_host (
  output logic tck_out,
  output logic trstn_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  logic oe_seen;

  // idle levels follow the pull-ups; tck stands low between frames
  initial begin
    tck_out = 1'b0;
    trstn_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    oe_seen = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one 64 ns period; tdo taken at the rising edge that it is sampled on
  task automatic step(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #32;
    q = tdo_in;
    if (tdo_oe_in === 1'b1) oe_seen = 1'b1;
    tck_out = 1'b1;
    #32;
    tck_out = 1'b0;
  endtask : step

  task automatic set_trst(input logic v);
    trstn_out = v;
  endtask : set_trst

  // five ones reach reset from any state, then park in idle
  task automatic reset_tap();
    logic q;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : reset_tap

  // idle to idle, eight bits lsb first
  task automatic shift_ir(input logic [7:0] op, output logic [7:0] cap);
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < 8; i++) step(i == 7, op[i], cap[i]);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : shift_ir

  // idle to idle, len bits of din lsb first
  task automatic shift_dr(input int len, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < len; i++) step(i == len - 1, din[i], dout[i]);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : shift_dr
endmodule : jsg_jtag_host

// [tb/jsg_gate_test.sv]
// self-checking bench for the test port and programming gate
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL at %0t got %h expected %h", $time, g, e); end end

module jsg_gate_test;
  localparam logic [31:0] ID = 32'h1234_5679; // arbitrary value
  localparam logic [31:0] UC = 32'h0000_00a5;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic freeze_in = 1'b0;
  logic req_ready_in = 1'b0;
  logic [3:0] pad_in = 4'h0;
  logic [3:0] core_out_in = 4'h0;
  logic [3:0] core_oe_in = 4'h0;
  logic tck_in, trstn_in, tms_in, tdi_in, tdo_out, tdo_oe_out;
  logic [3:0] pad_out_out, pad_oe_out, core_in_out;
  logic req_valid_out, rej_out;
  jsg_pkg::jsg_req_t req_out;
  jsg_pkg::jsg_lock_t lock_out;
  jsg_pkg::jsg_req_t got_q[$];
  int n_rej = 0;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] q;
  logic [7:0] cap;

  jsg_gate #(.N_PINS(4), .ID_CODE(ID), .USER_CODE(UC), .FIFO_D(8)) u_dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .tck_in(tck_in), .trstn_in(trstn_in),
    .tms_in(tms_in), .tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .freeze_in(freeze_in), .pad_in(pad_in), .core_out_in(core_out_in),
    .core_oe_in(core_oe_in), .pad_out_out(pad_out_out), .pad_oe_out(pad_oe_out),
    .core_in_out(core_in_out), .req_valid_out(req_valid_out), .req_out(req_out),
    .req_ready_in(req_ready_in), .rej_out(rej_out), .lock_out(lock_out));

  jsg_jtag_host u_host (.tck_out(tck_in), .trstn_out(trstn_in), .tms_out(tms_in),
    .tdi_out(tdi_in), .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));

  always #10 core_clk_in = ~core_clk_in;

  // record taken words and refusal pulses
  always @(posedge core_clk_in) begin
    if (req_valid_out === 1'b1 && req_ready_in === 1'b1) got_q.push_back(req_out);
    if (rej_out === 1'b1) n_rej++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask : wait_core

  // both resets together; tck pulses while test reset is low
  task automatic do_reset();
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    u_host.set_trst(1'b0);
    u_host.reset_tap();
    @(posedge core_clk_in);
    rstn_in <= 1'b1;
    u_host.set_trst(1'b1);
    wait_core(2);
    u_host.reset_tap();
  endtask : do_reset

  task automatic ir(input logic [7:0] op);
    u_host.shift_ir(op, cap);
    `CHK(cap, jsg_pkg::IR_CAPTURE)
  endtask : ir

  // word sent at update; busy is what capture saw before it
  task automatic word(input logic [2:0] c, input logic [7:0] d, output logic busy);
    u_host.shift_dr(11, {21'h0, c, d}, q);
    busy = q[0];
    wait_core(8);
  endtask : word

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_codes();
    logic [7:0] byp[2] = '{jsg_pkg::OP_BYPASS, 8'h55};
    u_host.shift_dr(32, 32'h0, q);
    `CHK(q, ID)
    ir(jsg_pkg::OP_USERCODE);
    u_host.shift_dr(32, 32'h0, q);
    `CHK(q, UC)
    ir(jsg_pkg::OP_IDCODE);
    u_host.shift_dr(32, 32'h0, q);
    `CHK(q, ID)
    foreach (byp[i]) begin
      ir(byp[i]);
      u_host.shift_dr(8, 32'hb3, q);
      `CHK(q[7:0], 8'h66)
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_boundary();
    logic [7:0] ops[3] = '{jsg_pkg::OP_EXTEST, jsg_pkg::OP_CLAMP, jsg_pkg::OP_HIGHZ};
    logic [11:0] pre, exp;
    @(posedge core_clk_in);
    pad_in <= 4'ha;
    core_out_in <= 4'h6;
    core_oe_in <= 4'hc;
    // per pin {enable, output, input} for pads a, outputs 6, enables c
    exp = 12'hb98;
    // preload enables pins 0, 2 and 3, outputs pins 1 and 2
    for (int i = 0; i < 4; i++) begin
      pre[3*i +: 3] = {~i[0] | i[1], i[0] ^ i[1], 1'b0};
    end
    wait_core(4);
    ir(jsg_pkg::OP_SAMPLE);
    u_host.shift_dr(12, {20'h0, pre}, q);
    `CHK(q[11:0], exp)
    `CHK(core_in_out, 4'ha)
    foreach (ops[k]) begin
      ir(ops[k]);
      wait_core(10);
      `CHK(pad_oe_out, (k == 2) ? 4'h0 : 4'hd)
      if (k != 2) `CHK(pad_out_out, 4'h6)
    end
    $display("test boundary done");
  endtask : t_boundary

  task automatic t_locks();
    logic [2:0] cm[7] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h6, 3'h4, 3'h4};
    logic [7:0] dt[7] = '{8'h01, 8'h11, 8'h22, 8'h33, 8'h44, 8'h02, 8'h00};
    logic rj[7] = '{0, 1, 0, 0, 1, 0, 1};
    logic [2:0] lk[7] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
    logic b;
    int nr, ng;
    ir(jsg_pkg::OP_PROG);
    @(posedge core_clk_in);
    req_ready_in <= 1'b1;
    foreach (cm[k]) begin
      nr = n_rej;
      ng = got_q.size();
      word(cm[k], dt[k], b);
      `CHK(n_rej - nr, int'(rj[k]))
      `CHK(got_q.size() - ng, int'(!rj[k] && cm[k] != 3'h4))
      `CHK(lock_out, lk[k])
      if (got_q.size() > ng) `CHK(got_q[ng], {cm[k], dt[k]})
    end
    do_reset();
    `CHK(lock_out, 3'h0)
    ir(jsg_pkg::OP_PROG);
    word(3'h4, 8'h04, b);
    nr = n_rej;
    ng = got_q.size();
    for (int c = 0; c < 5; c++) word(c[2:0], 8'h3c, b);
    `CHK(n_rej - nr, 5)
    `CHK(got_q.size() - ng, 0)
    `CHK(lock_out, 3'h4)
    $display("test locks done");
  endtask : t_locks

  task automatic t_fifo();
    logic b = 1'b0;
    int n = 0;
    do_reset();
    ir(jsg_pkg::OP_PROG);
    @(posedge core_clk_in);
    req_ready_in <= 1'b0;
    got_q.delete();
    while (!b && n < 16) begin
      word(jsg_pkg::CMD_MEM_WR, n[7:0], b);
      if (!b) n++;
    end
    `CHK(b, 1'b1)
    `CHK(n > 7, 1'b1)
    `CHK(req_valid_out, 1'b1)
    @(posedge core_clk_in);
    req_ready_in <= 1'b1;
    wait_core(40);
    `CHK(got_q.size(), n)
    foreach (got_q[k]) `CHK(got_q[k], {jsg_pkg::CMD_MEM_WR, k[7:0]})
    `CHK(req_valid_out, 1'b0)
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_freeze();
    @(posedge core_clk_in);
    freeze_in <= 1'b1;
    u_host.reset_tap();
    u_host.oe_seen = 1'b0;
    u_host.shift_ir(jsg_pkg::OP_BYPASS, cap);
    u_host.shift_dr(32, 32'h0, q);
    `CHK(u_host.oe_seen, 1'b0)
    @(posedge core_clk_in);
    freeze_in <= 1'b0;
    u_host.reset_tap();
    u_host.shift_dr(32, 32'h0, q);
    `CHK(q, ID)
    $display("test freeze done");
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // whole run is well under half a millisecond
  initial begin
    #1ms;
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    repeat (10) @(posedge core_clk_in);
    do_reset();
    t_codes();
    t_boundary();
    t_locks();
    t_fifo();
    t_freeze();
    finish_test();
  end
endmodule : jsg_gate_test
